// file: rtl/lhsb_bank.sv
// Purpose: read-only link health status bank with a write-only clear control register behind AXI4-Lite
// Assumes: status inputs synchronous to clk; one read and one write at a time
// Notes: clear-on-read effects fire when the read data is latched
`timescale 1ns/1ps
// Functional notes
// - checksum ok bit set at init end only if fuse checksum was valid
// - init complete bit set once power-up init and fuse load finish
// - remote receiver lock shown on status bit
// - loss-changed flag set on any change of link-detect lost status
// - loss-changed flag cleared by fault clear control or pll unlock
// - self-test error sets fault flag and increments 8-bit counter
// - fast pll lock bit mirrors pll input, unregistered, so reset does not set it
// - check fault set on back-channel error while link detected
// - check fault cleared by fault clear control
// - link valid bit follows back-channel link input, unregistered, so reset does not set it
// - pin levels field shows present four pin inputs
// - 16-bit check error count, low byte then high byte address
// - temperature over/under flags set by alarms, cleared on read
// - pin1 voltage over/under flags set by alarms, cleared on read
// - pin0 voltage over/under flags set by alarms, cleared on read
// - pin0 peak reading captured above limit, zero means none, read clears
// - pin0 trough reading captured below limit, seven means none, read clears
// - writing one to counter clear zeroes self-test count, self-clearing
module lhsb_bank
  import lhsb_pkg::*;
#(
  parameter logic [3:0] SILICON_REV = 4'h5, // arbitrary value
  parameter logic [3:0] PHOTOMASK = 4'hA // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // axi write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // power-up status
  input wire logic initDone,
  input wire logic fuseCksumValid,
  // link status
  input wire logic remoteRxLocked,
  input wire logic linkLost,
  input wire logic linkValid,
  input wire logic fastPllLocked,
  input wire logic backlinkError,
  input wire logic selftestError,
  // pins and sensors
  input wire logic [3:0] pinIn,
  input wire logic tempOver,
  input wire logic tempUnder,
  input wire logic pin1Over,
  input wire logic pin1Under,
  input wire logic pin0Over,
  input wire logic pin0Under,
  input wire logic [2:0] pin0Reading
);
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic awHave_q, wHave_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdIdx, wrIdx, rdByte;
  logic rdTake, wrTake, rdHit, rdAlarm, rdExt, chkClr, cntClr;
  logic initDone_q, cksumOk_q, linkLost_q, lossChg_q, stFault_q, chkFault_q;
  logic [7:0] stCnt_q;
  logic [15:0] chkCnt_q;
  logic [5:0] alarm_q, alarmIn;
  logic [2:0] peak, trough;

  // write channel: address and data taken in either order
  assign awready = !awHave_q && !bvalid_q;
  assign wready = !wHave_q && !bvalid_q;
  assign wrTake = awHave_q && wHave_q && !bvalid_q;
  assign wrIdx = awaddr_q[9:2];
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      awHave_q <= 1'b0;
      awaddr_q <= 32'h00000000;
    end else if (awvalid && awready) begin
      awHave_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wrTake) begin
      awHave_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wHave_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wHave_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wrTake) begin
      wHave_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wrTake) begin
      bvalid_q <= 1'b1;
      if (wrIdx == IDX_CTRL && awaddr_q[31:10] == 22'h0) begin
        bresp_q <= RESP_OKAY;
      end else if (awaddr_q[31:10] == 22'h0 && wrIdx >= IDX_REV && wrIdx <= IDX_PIN0_EXT) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control strobes are single-cycle: the bits self-clear
  assign chkClr = wrTake && wrIdx == IDX_CTRL && awaddr_q[31:10] == 22'h0
                  && wstrb_q[0] && wdata_q[BIT_CHK_CLR];
  assign cntClr = wrTake && wrIdx == IDX_CTRL && awaddr_q[31:10] == 22'h0
                  && wstrb_q[0] && wdata_q[BIT_ST_CNT_CLR];

  // read channel
  assign arready = !rvalid_q;
  assign rdTake = arvalid && arready;
  assign rdIdx = araddr[9:2];
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rdAlarm = rdTake && rdHit && rdIdx == IDX_ALARM;
  assign rdExt = rdTake && rdHit && rdIdx == IDX_PIN0_EXT;

  always_comb begin
    rdHit = araddr[31:10] == 22'h0;
    rdByte = 8'h00;
    if (rdIdx == IDX_REV) begin
      rdByte = {SILICON_REV, PHOTOMASK};
    end else if (rdIdx == IDX_INIT) begin
      rdByte = {cksumOk_q, initDone_q, 6'h00};
    end else if (rdIdx == IDX_GEN) begin
      rdByte = 8'h00;
      rdByte[BIT_RX_LOCK] = remoteRxLocked;
      rdByte[BIT_LOSS_CHG] = lossChg_q;
      rdByte[BIT_ST_FAULT] = stFault_q;
      rdByte[BIT_PLL_LOCK] = fastPllLocked;
      rdByte[BIT_CHK_FAULT] = chkFault_q;
      rdByte[BIT_LINK_VALID] = linkValid;
    end else if (rdIdx == IDX_PINS) begin
      rdByte = {4'h0, pinIn};
    end else if (rdIdx == IDX_SELFTEST) begin
      rdByte = stCnt_q;
    end else if (rdIdx == IDX_CHK_LO) begin
      rdByte = chkCnt_q[7:0];
    end else if (rdIdx == IDX_CHK_HI) begin
      rdByte = chkCnt_q[15:8];
    end else if (rdIdx == IDX_ALARM) begin
      rdByte = {2'h0, alarm_q};
    end else if (rdIdx == IDX_PIN0_EXT) begin
      rdByte = {1'b0, peak, 1'b0, trough};
    end else if (rdIdx == IDX_CTRL) begin
      rdByte = 8'h00;
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (rdTake) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rdByte};
      rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      initDone_q <= 1'b0;
      cksumOk_q <= 1'b0;
    end else if (initDone && !initDone_q) begin
      initDone_q <= 1'b1;
      cksumOk_q <= fuseCksumValid;
    end
  end

  // loss change flag, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      linkLost_q <= 1'b0;
      lossChg_q <= 1'b0;
    end else begin
      linkLost_q <= linkLost;
      if (linkLost != linkLost_q) begin
        lossChg_q <= 1'b1;
      end else if (chkClr || !fastPllLocked) begin
        lossChg_q <= 1'b0;
      end
    end
  end

  // check fault, counted while link detected
  always_ff @(posedge clk) begin
    if (srst) begin
      chkFault_q <= 1'b0;
      chkCnt_q <= CNT16_RST;
    end else begin
      if (backlinkError && linkValid) begin
        chkFault_q <= 1'b1;
      end else if (chkClr) begin
        chkFault_q <= 1'b0;
      end
      // counter saturates so wrap never hides a burst
      if (backlinkError && linkValid && chkCnt_q != 16'hFFFF) begin
        chkCnt_q <= chkCnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stFault_q <= 1'b0;
      stCnt_q <= CNT8_RST;
    end else begin
      if (selftestError) begin
        stFault_q <= 1'b1;
      end else if (cntClr) begin
        stFault_q <= 1'b0;
      end
      if (cntClr) begin
        stCnt_q <= selftestError ? 8'h01 : CNT8_RST;
      end else if (selftestError && stCnt_q != 8'hFF) begin
        stCnt_q <= stCnt_q + 8'h01;
      end
    end
  end

  // sticky alarms, set wins over read
  always_comb begin
    alarmIn = 6'h00;
    alarmIn[BIT_T_OVER] = tempOver;
    alarmIn[BIT_T_UNDER] = tempUnder;
    alarmIn[BIT_V1_OVER] = pin1Over;
    alarmIn[BIT_V1_UNDER] = pin1Under;
    alarmIn[BIT_V0_OVER] = pin0Over;
    alarmIn[BIT_V0_UNDER] = pin0Under;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_q <= 6'h00;
    end else if (rdAlarm) begin
      alarm_q <= alarmIn;
    end else begin
      alarm_q <= alarm_q | alarmIn;
    end
  end

  lhsb_extreme #(
    .IS_PEAK(1'b1),
    .IDLE(PEAK_IDLE)
  ) u_peak (
    .clk(clk),
    .srst(srst),
    .alarm(pin0Over),
    .reading(pin0Reading),
    .clearRd(rdExt),
    .value(peak)
  );

  lhsb_extreme #(
    .IS_PEAK(1'b0),
    .IDLE(TROUGH_IDLE)
  ) u_trough (
    .clk(clk),
    .srst(srst),
    .alarm(pin0Under),
    .reading(pin0Reading),
    .clearRd(rdExt),
    .value(trough)
  );

  // assertions
  property p_cksum;
    @(posedge clk) disable iff (srst) $rose(initDone_q) |-> cksumOk_q == $past(fuseCksumValid);
  endproperty
  a_cksum: assert property (p_cksum) else $error("checksum bit wrong");
  property p_init;
    @(posedge clk) disable iff (srst) initDone && !initDone_q |=> initDone_q;
  endproperty
  a_init: assert property (p_init) else $error("init bit not set");
  // live input against last sample, else the two sides always agree
  property p_loss_set;
    @(posedge clk) disable iff (srst) linkLost != linkLost_q |=> lossChg_q;
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("loss flag not set");
  property p_loss_clr;
    @(posedge clk) disable iff (srst)
      (chkClr || !fastPllLocked) && linkLost == linkLost_q |=> !lossChg_q;
  endproperty
  a_loss_clr: assert property (p_loss_clr) else $error("loss flag not cleared");
  property p_st_cnt;
    @(posedge clk) disable iff (srst)
      selftestError && !cntClr && stCnt_q < 8'hFF |=> stCnt_q == $past(stCnt_q) + 8'h01;
  endproperty
  a_st_cnt: assert property (p_st_cnt) else $error("selftest count missed");
  property p_chk_set;
    @(posedge clk) disable iff (srst) backlinkError && linkValid |=> chkFault_q;
  endproperty
  a_chk_set: assert property (p_chk_set) else $error("check fault not set");
  property p_chk_clr;
    @(posedge clk) disable iff (srst) chkClr && !(backlinkError && linkValid) |=> !chkFault_q;
  endproperty
  a_chk_clr: assert property (p_chk_clr) else $error("check fault not cleared");
  property p_alarm_hold;
    @(posedge clk) disable iff (srst) !rdAlarm && alarm_q[BIT_T_OVER] |=> alarm_q[BIT_T_OVER];
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost");
  property p_rd_resp;
    @(posedge clk) disable iff (srst) rdTake |=> rvalid && rdata[31:8] == 24'h0;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_trough_idle;
    @(posedge clk) disable iff (srst) rdExt && !pin0Under |=> trough == TROUGH_IDLE;
  endproperty
  a_trough_idle: assert property (p_trough_idle) else $error("trough not reset");
  c_write: cover property (@(posedge clk) disable iff (srst) wrTake ##1 bvalid);
  c_alarm_rd: cover property (@(posedge clk) disable iff (srst) alarm_q != 6'h0 ##1 rdAlarm);
  c_chk_clr: cover property (@(posedge clk) disable iff (srst) chkFault_q ##1 chkClr);
endmodule // lhsb_bank

// file: rtl/lhsb_extreme.sv
// Purpose: sticky clear-on-read peak or trough of a 3-bit reading
// Assumes: reading and alarm are synchronous to clk
// Notes: IS_PEAK selects max tracking, else min tracking
`timescale 1ns/1ps
module lhsb_extreme #(
  parameter bit IS_PEAK = 1'b1,
  parameter logic [2:0] IDLE = 3'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // sensor side
  input wire logic alarm,
  input wire logic [2:0] reading,
  // register side
  input wire logic clearRd,
  output logic [2:0] value
);
  logic [2:0] value_q;
  logic better;

  assign better = IS_PEAK ? (reading > value_q) : (reading < value_q);
  assign value = value_q;

  // a reading in the clearing cycle wins so no excursion is missed
  always_ff @(posedge clk) begin
    if (srst) begin
      value_q <= IDLE;
    end else if (alarm && (better || clearRd)) begin
      value_q <= reading;
    end else if (clearRd) begin
      value_q <= IDLE;
    end
  end
endmodule // lhsb_extreme

// file: rtl/lhsb_pkg.sv
// Purpose: constants for the link health status bank
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes: printed offsets are register indices; byte address is index * 4
package lhsb_pkg;
  localparam logic [7:0] IDX_REV = 8'h50;
  localparam logic [7:0] IDX_INIT = 8'h51;
  localparam logic [7:0] IDX_GEN = 8'h52;
  localparam logic [7:0] IDX_PINS = 8'h53;
  localparam logic [7:0] IDX_SELFTEST = 8'h54;
  localparam logic [7:0] IDX_CHK_LO = 8'h55;
  localparam logic [7:0] IDX_CHK_HI = 8'h56;
  localparam logic [7:0] IDX_ALARM = 8'h57;
  localparam logic [7:0] IDX_PIN0_EXT = 8'h58;
  // own control register: fault clear and counter clear strobes
  localparam logic [7:0] IDX_CTRL = 8'h49;
  // device_init_status fields
  localparam int BIT_CKSUM_OK = 7;
  localparam int BIT_INIT_DONE = 6;
  // link_general_status fields
  localparam int BIT_RX_LOCK = 6;
  localparam int BIT_LOSS_CHG = 4;
  localparam int BIT_ST_FAULT = 3;
  localparam int BIT_PLL_LOCK = 2;
  localparam int BIT_CHK_FAULT = 1;
  localparam int BIT_LINK_VALID = 0;
  // control fields
  localparam int BIT_ST_CNT_CLR = 5;
  localparam int BIT_CHK_CLR = 3;
  // alarm flag fields
  localparam int BIT_T_OVER = 5;
  localparam int BIT_T_UNDER = 4;
  localparam int BIT_V1_OVER = 3;
  localparam int BIT_V1_UNDER = 2;
  localparam int BIT_V0_OVER = 1;
  localparam int BIT_V0_UNDER = 0;
  // extremes field positions and no-alarm values
  localparam int PEAK_LSB = 4;
  localparam int TROUGH_LSB = 0;
  localparam logic [2:0] PEAK_IDLE = 3'h0;
  localparam logic [2:0] TROUGH_IDLE = 3'h7;
  // reset values
  localparam logic PLL_LOCK_RST = 1'h1;
  localparam logic LINK_VALID_RST = 1'h1;
  localparam logic [7:0] CNT8_RST = 8'h00;
  localparam logic [15:0] CNT16_RST = 16'h0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verification/tb_link_health_status_bank.sv
// Purpose: self-checking bench for the link health status bank
// Assumes: AXI4-Lite master, one read or write at a time, inputs driven on rising edges
// Notes: byte address is register index times four; no partner model
`timescale 1ns/1ps
module tb_link_health_status_bank
  import lhsb_pkg::*;
;
  // bus and clock
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, pinIn;
  logic [1:0] bresp, rresp;
  // status inputs
  logic initDone, fuseCksumValid, remoteRxLocked, linkLost, linkValid, fastPllLocked;
  logic backlinkError, selftestError, tempOver, tempUnder, pin1Over, pin1Under;
  logic pin0Over, pin0Under;
  logic [2:0] pin0Reading;
  int miscompares = 0;
  int nChecks = 0;

  // identity values are arbitrary
  lhsb_bank #(.SILICON_REV(4'h3), .PHOTOMASK(4'h9)) lhsb_bank_i (
    .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .initDone, .fuseCksumValid, .remoteRxLocked, .linkLost, .linkValid,
    .fastPllLocked, .backlinkError, .selftestError, .pinIn, .tempOver, .tempUnder,
    .pin1Over, .pin1Under, .pin0Over, .pin0Under, .pin0Reading
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (miscompares == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // master holds each channel until its own handshake edge
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] re);
    @(posedge clk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        chk({30'h0, rresp}, {30'h0, re});
        chk(rdata, {24'h0, exp});
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] re);
    @(posedge clk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        chk({30'h0, bresp}, {30'h0, re});
        break;
      end
    end
  endtask

  task automatic t_reset();
    rdChk(IDX_REV, 8'h39, RESP_OKAY);
    rdChk(IDX_INIT, 8'h00, RESP_OKAY);
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
    rdChk(IDX_SELFTEST, 8'h00, RESP_OKAY);
    rdChk(IDX_CHK_LO, 8'h00, RESP_OKAY);
    rdChk(IDX_CHK_HI, 8'h00, RESP_OKAY);
    rdChk(IDX_ALARM, 8'h00, RESP_OKAY);
    rdChk(IDX_PIN0_EXT, 8'h07, RESP_OKAY);
  endtask

  task automatic t_init();
    initDone <= 1'h1;
    rdChk(IDX_INIT, 8'hC0, RESP_OKAY);
  endtask

  task automatic t_status();
    remoteRxLocked <= 1'h1;
    fastPllLocked <= 1'h0;
    linkValid <= 1'h0;
    pinIn <= 4'hA;
    rdChk(IDX_GEN, 8'h40, RESP_OKAY);
    rdChk(IDX_PINS, 8'h0A, RESP_OKAY);
    remoteRxLocked <= 1'h0;
    fastPllLocked <= 1'h1;
    linkValid <= 1'h1;
    pinIn <= 4'h5;
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
    rdChk(IDX_PINS, 8'h05, RESP_OKAY);
  endtask

  task automatic t_loss();
    linkLost <= 1'h1;
    rdChk(IDX_GEN, 8'h15, RESP_OKAY);
    wr(IDX_CTRL, 8'h08, RESP_OKAY);
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
    linkLost <= 1'h0;
    rdChk(IDX_GEN, 8'h15, RESP_OKAY);
    fastPllLocked <= 1'h0;
    rdChk(IDX_GEN, 8'h01, RESP_OKAY);
    fastPllLocked <= 1'h1;
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
  endtask

  // errors without link detect must not count
  task automatic t_check();
    linkValid <= 1'h0;
    backlinkError <= 1'h1;
    tick(1);
    backlinkError <= 1'h0;
    linkValid <= 1'h1;
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
    backlinkError <= 1'h1;
    tick(259);
    backlinkError <= 1'h0;
    rdChk(IDX_GEN, 8'h07, RESP_OKAY);
    rdChk(IDX_CHK_LO, 8'h03, RESP_OKAY);
    rdChk(IDX_CHK_HI, 8'h01, RESP_OKAY);
    // clear needs byte lane zero enabled
    wstrb <= 4'h0;
    wr(IDX_CTRL, 8'h08, RESP_OKAY);
    rdChk(IDX_GEN, 8'h07, RESP_OKAY);
    wstrb <= 4'hF;
    wr(IDX_CTRL, 8'h08, RESP_OKAY);
    rdChk(IDX_GEN, 8'h05, RESP_OKAY);
  endtask

  task automatic t_selftest();
    selftestError <= 1'h1;
    tick(2);
    selftestError <= 1'h0;
    rdChk(IDX_GEN, 8'h0D, RESP_OKAY);
    rdChk(IDX_SELFTEST, 8'h02, RESP_OKAY);
    wr(IDX_CTRL, 8'h20, RESP_OKAY);
    rdChk(IDX_SELFTEST, 8'h00, RESP_OKAY);
    rdChk(IDX_CTRL, 8'h00, RESP_OKAY);
  endtask

  // peak of 3,5,2 and trough of 4,1,6
  task automatic t_sensor();
    pin0Reading <= 3'h3;
    {tempOver, tempUnder, pin1Over, pin1Under, pin0Over, pin0Under} <= 6'h3E;
    tick(1);
    pin0Reading <= 3'h5;
    tick(1);
    pin0Reading <= 3'h2;
    tick(1);
    {tempOver, tempUnder, pin1Over, pin1Under, pin0Over, pin0Under} <= 6'h01;
    pin0Reading <= 3'h4;
    tick(1);
    pin0Reading <= 3'h1;
    tick(1);
    pin0Reading <= 3'h6;
    tick(1);
    {tempOver, tempUnder, pin1Over, pin1Under, pin0Over, pin0Under} <= 6'h00;
    rdChk(IDX_ALARM, 8'h3F, RESP_OKAY);
    rdChk(IDX_ALARM, 8'h00, RESP_OKAY);
    rdChk(IDX_PIN0_EXT, 8'h51, RESP_OKAY);
    rdChk(IDX_PIN0_EXT, 8'h07, RESP_OKAY);
    pin0Over <= 1'h1;
    pin0Reading <= 3'h2;
    tick(1);
    pin0Over <= 1'h0;
    rdChk(IDX_PIN0_EXT, 8'h27, RESP_OKAY);
    rdChk(IDX_ALARM, 8'h02, RESP_OKAY);
  endtask

  task automatic t_access();
    wr(8'h5B, 8'h12, RESP_SLVERR);
    rdChk(8'h5B, 8'h00, RESP_SLVERR);
    wr(IDX_REV, 8'hFF, RESP_OKAY);
    rdChk(IDX_REV, 8'h39, RESP_OKAY);
  endtask

  // second reset with a bad fuse checksum
  task automatic t_rereset();
    srst <= 1'h1;
    fuseCksumValid <= 1'h0;
    tick(2);
    srst <= 1'h0;
    rdChk(IDX_INIT, 8'h40, RESP_OKAY);
  endtask

  initial begin
    srst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    pinIn = 4'h0;
    {initDone, fuseCksumValid, remoteRxLocked, linkLost} = 4'h4;
    {linkValid, fastPllLocked, backlinkError, selftestError} = 4'hC;
    {tempOver, tempUnder, pin1Over, pin1Under, pin0Over, pin0Under} = 6'h00;
    pin0Reading = 3'h0;
    tick(2);
    srst <= 1'h0;
    t_reset();
    t_init();
    t_status();
    t_loss();
    t_check();
    t_selftest();
    t_sensor();
    t_access();
    t_rereset();
    tally_and_finish();
  end

  // whole run is well under a thousand cycles
  initial begin
    tick(5000);
    miscompares++;
    tally_and_finish();
  end
endmodule // tb_link_health_status_bank
